/* File: core/porl_pkg.sv */
// Contract
// - Trip output stays active after activation until a qualified reset.
// - Reset key releases trip only if motor permits; emergency restart always releases.
// - Single-shot restart, when enabled, auto-resets trip once after running overload trip.
// - Fail-safe relay coil energized when idle, de-energized when active.
// - No trip reset accepted while a lock-out timer is running; emergency restart still releases trip and clears the timer.
// - Lock-out time keeps counting regardless of control power.
// - Trip activates on OR of masked trip conditions.
// - Defaults: trip fail-safe, alarm and aux1 non-fail-safe, aux2 fail-safe.
// - Alarm relay takes alarm-level conditions only.
// - Alarm mask covers the ten listed alarm conditions.
// - Alarm relay has own latch and fail-safe selections.
// - Aux1 independent, own mask over any trip or alarm condition.
// - Aux1 has latch and fail-safe selections.
// - Aux2 always latched and fail-safe.
// - Aux2 mask takes alarm conditions only, same set as alarm relay.
// - Inputs one to programmed count (max 6) are stator sensors.
// - Setpoint selects last temperature input as ambient sensor.
// - Learn cooling times when stator count nonzero, else use presets.
// - External reset contact acts as reset key, same qualification; here it also resets aux1 while cfg_aux1_key_reset_en blocks key reset.
package porl_pkg;
  localparam int NUM_TRIP          = 15;
  localparam int NUM_ALARM         = 10;
  localparam int NUM_SENSOR        = 10;
  localparam int MAX_STATOR        = 6;
  localparam int TRIP_BIT_OVERLOAD = 0;
  localparam logic TRIP_FS_RST     = 1'b1;
  localparam logic ALARM_FS_RST    = 1'b0;
  localparam logic AUX1_FS_RST     = 1'b0;
  localparam logic AUX2_FS_RST     = 1'b1;
  localparam int LOCKOUT_W         = 16;
  localparam int TICK_NS           = 1000000;
  localparam int CLK_NS            = 5;
  localparam int TICK_CYC          = TICK_NS / CLK_NS;
  typedef enum logic [1:0] {PORL_IDLE, PORL_TRIPPED, PORL_LOCKED}
    porl_trip_st_t;
endpackage

/* File: core/porl_lockout.sv */
`timescale 1ns/1ps
module porl_lockout #(
  parameter int W        = porl_pkg::LOCKOUT_W,
  parameter int TICK_CYC = porl_pkg::TICK_CYC
) (
  input  wire logic         clk_sys,
  input  wire logic         sys_rst,
  input  wire logic         load,
  input  wire logic [W-1:0] load_val,
  input  wire logic         elapsed_tick,
  input  wire logic         clear,
  output logic              running
);
  import porl_pkg::*;
  typedef struct packed {
    logic [W-1:0]  cnt;
    logic [31:0]   div;
    logic          run;
  } porl_lo_t;
  porl_lo_t s_reg, s_next;

  always_comb begin
    s_next = s_reg;
    if (s_reg.div == 32'(TICK_CYC - 1)) begin
      s_next.div = 32'h0000_0000;
    end else begin
      s_next.div = s_reg.div + 32'h0000_0001;
    end
    // Count real time; external tick covers time spent unpowered
    if (s_reg.cnt != '0 &&
        (s_reg.div == 32'(TICK_CYC - 1) || elapsed_tick)) begin
      s_next.cnt = s_reg.cnt - W'(1);
    end
    if (load) begin
      s_next.cnt = load_val;
    end
    if (clear) begin
      s_next.cnt = '0;
    end
    s_next.run = (s_next.cnt != '0);
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign running = s_reg.run;
endmodule // porl_lockout

/* File: core/porl_relay.sv */
`timescale 1ns/1ps
module porl_relay
  import porl_pkg::*;
#(
  parameter int NT = porl_pkg::NUM_TRIP,
  parameter int NA = porl_pkg::NUM_ALARM,
  parameter int NS = porl_pkg::NUM_SENSOR,
  parameter int LW = porl_pkg::LOCKOUT_W
) (
  input  wire logic          clk_sys,
  input  wire logic          sys_rst,
  input  wire logic [NT-1:0] trip_cond,
  input  wire logic [NA-1:0] alarm_cond,
  input  wire logic          motor_running,
  input  wire logic          reset_permit,
  input  wire logic          reset_key,
  input  wire logic          ext_reset,
  input  wire logic          emerg_restart,
  input  wire logic          lockout_start,
  input  wire logic [LW-1:0] lockout_time,
  input  wire logic          lockout_elapsed_tick,
  input  wire logic          cfg_load,
  input  wire logic [NT-1:0] cfg_trip_mask,
  input  wire logic          cfg_trip_fs,
  input  wire logic [NA-1:0] cfg_alarm_mask,
  input  wire logic          cfg_alarm_latch,
  input  wire logic          cfg_alarm_fs,
  input  wire logic [NT-1:0] cfg_aux1_trip_mask,
  input  wire logic [NA-1:0] cfg_aux1_alarm_mask,
  input  wire logic          cfg_aux1_latch,
  input  wire logic          cfg_aux1_fs,
  input  wire logic          cfg_aux1_key_reset_en,
  input  wire logic [NA-1:0] cfg_aux2_mask,
  input  wire logic          cfg_single_shot_en,
  input  wire logic [2:0]    cfg_stator_count,
  input  wire logic          cfg_ambient_en,
  output logic               trip_coil,
  output logic               alarm_coil,
  output logic               aux1_coil,
  output logic               aux2_coil,
  output logic               trip_active,
  output logic               alarm_active,
  output logic               aux1_active,
  output logic               aux2_active,
  output logic               lockout_active,
  output logic [NS-1:0]      stator_sel,
  output logic [NS-1:0]      ambient_sel,
  output logic               learn_cooling
);
  import porl_pkg::*;

  typedef struct packed {
    logic [NT-1:0] trip_mask;
    logic          trip_fs;
    logic [NA-1:0] alarm_mask;
    logic          alarm_latch;
    logic          alarm_fs;
    logic [NT-1:0] aux1_tmask;
    logic [NA-1:0] aux1_amask;
    logic          aux1_latch;
    logic          aux1_fs;
    logic          aux1_key_en;
    logic [NA-1:0] aux2_mask;
    logic          single_shot;
    logic [2:0]    stator_cnt;
    logic          ambient;
    porl_trip_st_t trip_st;
    logic          shot_used;
    logic          ovl_trip;
    logic          alarm_q;
    logic          aux1_q;
    logic          aux2_q;
    logic          trip_q;
    logic          trip_coil;
    logic          alarm_coil;
    logic          aux1_coil;
    logic          aux2_coil;
    logic          lock_q;
    logic [NS-1:0] stator_sel;
    logic [NS-1:0] ambient_sel;
    logic          learn;
  } porl_st_t;
  porl_st_t s_reg, s_next;

  logic lock_run;

  porl_lockout #(
    .W        (LW),
    .TICK_CYC (TICK_CYC)
  ) u_lockout (
    .clk_sys      (clk_sys),
    .sys_rst      (sys_rst),
    .load         (lockout_start),
    .load_val     (lockout_time),
    .elapsed_tick (lockout_elapsed_tick),
    .clear        (emerg_restart),
    .running      (lock_run)
  );

  logic trip_any, alarm_any, aux1_any, aux2_any;
  logic key_rst, qual_rst, trip_rel;

  always_comb begin
    s_next    = s_reg;
    trip_any  = |(trip_cond & s_reg.trip_mask);
    alarm_any = |(alarm_cond & s_reg.alarm_mask);
    aux1_any  = |(trip_cond & s_reg.aux1_tmask) |
                |(alarm_cond & s_reg.aux1_amask);
    aux2_any  = |(alarm_cond & s_reg.aux2_mask);
    key_rst   = reset_key | ext_reset;
    qual_rst  = key_rst & reset_permit & ~lock_run;
    trip_rel  = 1'b0;

    if (cfg_load) begin
      s_next.trip_mask   = cfg_trip_mask;
      s_next.trip_fs     = cfg_trip_fs;
      s_next.alarm_mask  = cfg_alarm_mask;
      s_next.alarm_latch = cfg_alarm_latch;
      s_next.alarm_fs    = cfg_alarm_fs;
      s_next.aux1_tmask  = cfg_aux1_trip_mask;
      s_next.aux1_amask  = cfg_aux1_alarm_mask;
      s_next.aux1_latch  = cfg_aux1_latch;
      s_next.aux1_fs     = cfg_aux1_fs;
      s_next.aux1_key_en = cfg_aux1_key_reset_en;
      s_next.aux2_mask   = cfg_aux2_mask;
      s_next.single_shot = cfg_single_shot_en;
      s_next.stator_cnt  = (cfg_stator_count > 3'(MAX_STATOR)) ?
                           3'(MAX_STATOR) : cfg_stator_count;
      s_next.ambient     = cfg_ambient_en;
    end

    case (s_reg.trip_st)
      PORL_IDLE: begin
        if (trip_any) begin
          s_next.trip_st  = PORL_TRIPPED;
          s_next.ovl_trip = trip_cond[TRIP_BIT_OVERLOAD] &
                            s_reg.trip_mask[TRIP_BIT_OVERLOAD] &
                            motor_running;
        end
      end
      PORL_TRIPPED: begin
        // Held regardless of cause clearing
        if (emerg_restart) begin
          trip_rel = 1'b1;
        end else if (lock_run) begin
          s_next.trip_st = PORL_LOCKED;
        end else if (qual_rst && !trip_any) begin
          trip_rel = 1'b1;
        end else if (s_reg.single_shot && s_reg.ovl_trip &&
                     !s_reg.shot_used && !trip_any) begin
          trip_rel         = 1'b1;
          s_next.shot_used = 1'b1;
        end
      end
      PORL_LOCKED: begin
        if (emerg_restart) begin
          trip_rel = 1'b1;
        end else if (!lock_run) begin
          s_next.trip_st = PORL_TRIPPED;
        end
      end
      default: begin
        s_next.trip_st = PORL_TRIPPED;
      end
    endcase
    if (trip_rel) begin
      s_next.trip_st  = PORL_IDLE;
      s_next.ovl_trip = 1'b0;
    end
    if (qual_rst && s_reg.trip_st == PORL_IDLE) begin
      s_next.shot_used = 1'b0;
    end

    // Latched relays hold; unlatched follow their conditions
    if (alarm_any) begin
      s_next.alarm_q = 1'b1;
    end else if (!s_reg.alarm_latch || qual_rst) begin
      s_next.alarm_q = 1'b0;
    end
    if (aux1_any) begin
      s_next.aux1_q = 1'b1;
    end else if (!s_reg.aux1_latch ||
                 ((reset_key & s_reg.aux1_key_en | ext_reset) &
                  reset_permit & ~lock_run)) begin
      s_next.aux1_q = 1'b0;
    end
    if (aux2_any) begin
      s_next.aux2_q = 1'b1;
    end else if (qual_rst) begin
      s_next.aux2_q = 1'b0;
    end

    // Coil level: fail-safe inverts activation
    s_next.trip_coil  = (s_next.trip_st != PORL_IDLE) ^ s_reg.trip_fs;
    s_next.alarm_coil = s_next.alarm_q ^ s_reg.alarm_fs;
    s_next.aux1_coil  = s_next.aux1_q ^ s_reg.aux1_fs;
    s_next.aux2_coil  = ~s_next.aux2_q;
    s_next.lock_q     = lock_run;
    s_next.trip_q     = (s_next.trip_st != PORL_IDLE);

    for (int i = 0; i < NS; i++) begin
      s_next.stator_sel[i] = (i < int'(s_reg.stator_cnt));
    end
    s_next.ambient_sel         = '0;
    s_next.ambient_sel[NS-1]   = s_reg.ambient;
    s_next.learn = (s_reg.stator_cnt != 3'h0);
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      s_reg             <= '0;
      s_reg.trip_st     <= PORL_IDLE;
      s_reg.trip_fs     <= TRIP_FS_RST;
      s_reg.alarm_fs    <= ALARM_FS_RST;
      s_reg.aux1_fs     <= AUX1_FS_RST;
      s_reg.aux1_key_en <= 1'b1;
      s_reg.alarm_latch <= 1'b1;
      s_reg.aux1_latch  <= 1'b1;
      s_reg.trip_coil   <= TRIP_FS_RST;
      s_reg.aux2_coil   <= AUX2_FS_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  assign trip_coil      = s_reg.trip_coil;
  assign alarm_coil     = s_reg.alarm_coil;
  assign aux1_coil      = s_reg.aux1_coil;
  assign aux2_coil      = s_reg.aux2_coil;
  assign trip_active    = s_reg.trip_q;
  assign alarm_active   = s_reg.alarm_q;
  assign aux1_active    = s_reg.aux1_q;
  assign aux2_active    = s_reg.aux2_q;
  assign lockout_active = s_reg.lock_q;
  assign stator_sel     = s_reg.stator_sel;
  assign ambient_sel    = s_reg.ambient_sel;
  assign learn_cooling  = s_reg.learn;
endmodule // porl_relay

/* File: verif/porl_relay_monitor.sv */
`timescale 1ns/1ps
module porl_relay_monitor
  import porl_pkg::*;
#(
  parameter int NT = NUM_TRIP,
  parameter int NS = NUM_SENSOR,
  parameter int LW = LOCKOUT_W
) (
  input wire logic          clk_sys,
  input wire logic          sys_rst,
  input wire logic [NT-1:0] trip_cond,
  input wire logic          reset_key,
  input wire logic          ext_reset,
  input wire logic          emerg_restart,
  input wire logic          lockout_start,
  input wire logic [LW-1:0] lockout_time,
  input wire logic          cfg_load,
  input wire logic          cfg_single_shot_en,
  input wire logic [2:0]    cfg_stator_count,
  input wire logic          cfg_ambient_en,
  input wire logic          trip_active,
  input wire logic          alarm_active,
  input wire logic          aux2_coil,
  input wire logic          aux2_active,
  input wire logic          lockout_active,
  input wire logic [NS-1:0] stator_sel,
  input wire logic [NS-1:0] ambient_sel,
  input wire logic          learn_cooling
);
  logic          rq_d1, rq_d2, em_d1, em_d2, quiet, em_quiet;
  logic [NS-1:0] exp_sel;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      {rq_d1, rq_d2, em_d1, em_d2} <= 4'h0;
    end else begin
      rq_d1 <= reset_key | ext_reset | emerg_restart;
      rq_d2 <= rq_d1;
      em_d1 <= emerg_restart;
      em_d2 <= em_d1;
    end
  end
  always_comb begin
    quiet = !(reset_key | ext_reset | emerg_restart | rq_d1 | rq_d2);
    em_quiet = !(emerg_restart | em_d1 | em_d2);
    for (int i = 0; i < NS; i++) begin
      exp_sel[i] = (i < int'(cfg_stator_count)) && (i < MAX_STATOR);
    end
  end
  a_aux2_fixed_fs: assert property (aux2_coil == !aux2_active)
    else $error("aux2 coil not fail-safe");
  a_trip_latched: assert property (trip_active && quiet
    && !cfg_single_shot_en |=> trip_active) else $error("trip dropped");
  a_lockout_block: assert property (trip_active && lockout_active
    && em_quiet |=> trip_active || !lockout_active)
    else $error("trip reset during lockout");
  a_emerg_release: assert property (emerg_restart
    && trip_cond == '0 |-> ##[1:3] !trip_active)
    else $error("emergency restart ignored");
  a_lockout_starts: assert property (lockout_start
    && lockout_time != '0 |-> ##2 lockout_active)
    else $error("lockout not running");
  a_stator_map: assert property (cfg_load |-> ##2
    stator_sel == $past(exp_sel, 2)) else $error("stator map wrong");
  a_ambient_map: assert property (cfg_load |-> ##2 ambient_sel
    == ($past(cfg_ambient_en, 2) << (NS - 1))) else $error("ambient");
  a_learn_cool: assert property (cfg_load |-> ##2 learn_cooling
    == ($past(cfg_stator_count, 2) != 3'h0)) else $error("learn wrong");
  c_trip: cover property ($rose(trip_active));
  c_lockout: cover property ($rose(lockout_active));
  c_alarm: cover property ($rose(alarm_active));
endmodule // porl_relay_monitor
bind porl_relay porl_relay_monitor #(.NT(NT), .NS(NS), .LW(LW)) u_mon (
  .clk_sys, .sys_rst, .trip_cond, .reset_key, .ext_reset, .emerg_restart,
  .lockout_start, .lockout_time, .cfg_load, .cfg_single_shot_en,
  .cfg_stator_count, .cfg_ambient_en, .trip_active, .alarm_active,
  .aux2_coil, .aux2_active, .lockout_active, .stator_sel, .ambient_sel,
  .learn_cooling);

/* File: verif/porl_contactor_model.sv */
`timescale 1ns/1ps
module porl_contactor_model (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic coil,
  input wire logic fs,
  output logic     motor_running
);
  // Trip contact in the contactor circuit; one cycle pick-up delay
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) motor_running <= 1'b0;
    else motor_running <= (coil == fs);
  end
endmodule // porl_contactor_model

/* File: verif/tb_porl_relay.sv */
`timescale 1ns/1ps
module tb_porl_relay;
  import porl_pkg::*;
  logic clk_sys = 0, sys_rst = 1, motor_running, reset_permit = 1;
  logic reset_key = 0, ext_reset = 0, emerg_restart = 0, cfg_load = 0;
  logic lockout_start = 0, lockout_elapsed_tick = 0, cfg_trip_fs = 1;
  logic cfg_alarm_latch = 1, cfg_alarm_fs = 0, cfg_aux1_latch = 1;
  logic cfg_aux1_fs = 0, cfg_aux1_key_reset_en = 1, cfg_ambient_en = 0;
  logic cfg_single_shot_en = 0;
  logic [2:0] cfg_stator_count = 0;
  logic [15:0] lockout_time = 0;
  logic [14:0] trip_cond = 0, cfg_trip_mask = 0, cfg_aux1_trip_mask = 0;
  logic [9:0] alarm_cond = 0, cfg_alarm_mask = 0, cfg_aux1_alarm_mask = 0;
  logic [9:0] cfg_aux2_mask = 0, stator_sel, ambient_sel, e;
  logic trip_coil, alarm_coil, aux1_coil, aux2_coil, trip_active;
  logic alarm_active, aux1_active, aux2_active, lockout_active;
  logic learn_cooling;
  int error_cnt = 0, cmp_count = 0;
  porl_relay u_porl_relay (.*);
  porl_contactor_model u_porl_contactor_model (.clk_sys(clk_sys),
    .sys_rst(sys_rst), .coil(trip_coil), .fs(cfg_trip_fs),
    .motor_running(motor_running));
  always #2.5 clk_sys = ~clk_sys;
  task automatic w(input int n); repeat (n) @(negedge clk_sys); endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    cmp_count++;
    if (g !== x) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask
  task automatic ld(); cfg_load = 1; w(1); cfg_load = 0; w(3); endtask
  task automatic key(); reset_key = 1; w(1); reset_key = 0; w(3); endtask
  task automatic ext(); ext_reset = 1; w(1); ext_reset = 0; w(3); endtask
  task automatic t_trip();
    for (int k = 0; k < 15; k++) begin
      cfg_trip_mask = 15'h0001 << k;
      ld();
      trip_cond = ~cfg_trip_mask;
      w(3);
      chk(trip_active, 0);
      trip_cond = cfg_trip_mask;
      w(3);
      chk({trip_active, trip_coil}, 2'b10);
      trip_cond = 0;
      w(3);
      chk(trip_active, 1);
      ext();
      chk(trip_active, 0);
    end
  endtask
  task automatic t_lock();
    cfg_trip_mask = 15'h0008; ld();
    trip_cond = 15'h0008; w(1); trip_cond = 0; reset_permit = 0;
    key();
    chk(trip_active, 1);
    reset_permit = 1; lockout_time = 16'h0002; lockout_start = 1;
    w(1); lockout_start = 0; w(3);
    key();
    chk({trip_active, lockout_active}, 2'b11);
    repeat (2) begin lockout_elapsed_tick = 1; w(1);
      lockout_elapsed_tick = 0; w(1); end
    w(3);
    chk(lockout_active, 0);
    key();
    chk(trip_active, 0);
    trip_cond = 15'h0008; lockout_start = 1; w(1);
    trip_cond = 0; lockout_start = 0; w(3);
    emerg_restart = 1; w(1); emerg_restart = 0; w(3);
    chk({trip_active, lockout_active}, 2'b00);
  endtask
  task automatic t_alarm();
    cfg_trip_mask = 0; cfg_alarm_mask = 10'h03ff;
    cfg_alarm_latch = 0; cfg_alarm_fs = 1;
    ld();
    trip_cond = 15'h7fff; w(3);
    chk({alarm_active, alarm_coil}, 2'b01);
    trip_cond = 0;
    for (int i = 0; i < 10; i++) begin
      alarm_cond = 10'h001 << i; w(3);
      chk({alarm_active, alarm_coil}, 2'b10);
      alarm_cond = 0; w(3);
      chk(alarm_active, 0);
    end
  endtask
  task automatic t_aux();
    cfg_aux1_trip_mask = 15'h0020; cfg_aux1_alarm_mask = 10'h200;
    cfg_aux2_mask = 10'h004; cfg_aux1_key_reset_en = 0; ld();
    trip_cond = 15'h0020; w(3); trip_cond = 0;
    chk({aux1_active, aux1_coil, trip_active}, 3'b110);
    alarm_cond = 10'h3fb; w(3);
    chk(aux2_active, 0);
    alarm_cond = 10'h004; w(3); alarm_cond = 0; w(3);
    chk({aux1_active, aux2_active, aux2_coil}, 3'b110);
    key();
    chk({aux1_active, aux2_active, aux2_coil}, 3'b101);
    ext();
    chk({aux1_active, aux2_active}, 2'b00);
    alarm_cond = 10'h200; w(3); alarm_cond = 0; w(3);
    chk(aux1_active, 1);
    ext(); cfg_aux1_key_reset_en = 1;
  endtask
  task automatic t_single();
    cfg_aux1_trip_mask = 0; cfg_trip_mask = 15'h0001;
    cfg_single_shot_en = 1; ld();
    trip_cond = 15'h0001; w(1); trip_cond = 0; w(8);
    chk(trip_active, 0);
    trip_cond = 15'h0001; w(1); trip_cond = 0; w(8);
    chk(trip_active, 1);
    cfg_single_shot_en = 0; ld(); key(); key();
    trip_cond = 15'h0001; w(1); trip_cond = 0; w(8);
    chk(trip_active, 1);
    ext();
  endtask
  task automatic t_rtd();
    for (int n = 0; n < 8; n++) begin
      cfg_stator_count = 3'(n); cfg_ambient_en = n[0]; ld();
      for (int i = 0; i < 10; i++) e[i] = (i < n) && (i < MAX_STATOR);
      chk({stator_sel, learn_cooling}, {e, n != 0});
      chk(ambient_sel, {n[0], 9'h000});
    end
  endtask
  task automatic report_and_stop();
    $display("error_cnt=%0d cmp_count=%0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    w(3); sys_rst = 0; w(1);
    chk({trip_coil, alarm_coil, aux1_coil, aux2_coil}, 4'b1001);
    t_trip(); t_lock(); t_alarm(); t_aux(); t_single(); t_rtd();
    report_and_stop();
  end
  initial begin #60000; error_cnt++; report_and_stop(); end
endmodule // tb_porl_relay
